// [design/srsp_pkg.sv]
// Shared constants and types of the stepper ramp and stop priority block
package srsp_pkg;
  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] A_CTRL = 8'h00; // motor_run_control_reg
  localparam logic [7:0] A_PDIR = 8'h04; // pin_direction_reg
  localparam logic [7:0] A_MASK = 8'h08; // pin_irq_mask_reg
  localparam logic [7:0] A_EDGE = 8'h0c; // pin_edge_select_reg
  localparam logic [7:0] A_ACT = 8'h10; // Per-pin reverse and extra-step enables
  localparam logic [7:0] A_ROT = 8'h14; // Programmed rotation step count
  localparam logic [7:0] A_XTRA = 8'h18; // Extra step count
  localparam logic [7:0] A_RAMP = 8'h1c; // Ramp length in steps
  localparam logic [7:0] A_STAT = 8'h20; // State and remaining count
  // ==========================================================
  // Field positions
  localparam int NPIN = 2; // Sense pins handled here
  localparam int C_DIR = 0; // 1 = counterclockwise
  localparam int C_HARD = 1; // Hard stop enable
  localparam int C_RDN = 2; // Ramp-down enable
  localparam int C_RUP = 3; // Ramp-up enable
  localparam int C_RUN = 7; // Write 1 start, write 0 stop
  localparam int ACT_XTRA_LSB = 2; // Extra-step enables sit above reverse enables
  // ==========================================================
  // Reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [1:0] PIN_RST = 2'h0;
  localparam logic [3:0] ACT_RST = 4'h0;
  localparam logic [15:0] ROT_RST = 16'h0010;
  localparam logic [7:0] XTRA_RST = 8'h04;
  localparam logic [7:0] RAMP_RST = 8'h08;
  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int STEP_PERIOD_NS = 1000; // Step period, least time
  localparam int STEP_CYC = (STEP_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // ==========================================================
  // Bus and state encodings
  localparam int HTRANS_ACTIVE_BIT = 1; // NONSEQ or SEQ
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_RAMPUP = 5'h02,
    ST_RUN = 5'h04,
    ST_EXTRA = 5'h08,
    ST_RAMPDN = 5'h10
  } srsp_state_t;
endpackage

// [design/srsp_top.sv]
// Stepper ramp, stop priority and sense-pin action logic with AHB-Lite registers
`timescale 1ns/1ns
module srsp_top #(
  parameter int STEP_DIV = srsp_pkg::STEP_CYC // Clock cycles per motor step
) (
  input wire logic CLK, // 100 MHz clock
  input wire logic RESETN, // Async reset, active low
  input wire logic HSEL, // Slave select
  input wire logic [7:0] HADDR, // Byte address
  input wire logic [1:0] HTRANS, // Transfer type
  input wire logic HWRITE, // Write when high
  input wire logic [2:0] HSIZE, // Word only
  input wire logic [31:0] HWDATA, // Write data
  input wire logic HREADY, // Bus ready
  output logic [31:0] HRDATA, // Read data
  output logic HREADYOUT, // Slave ready
  output logic HRESP, // Always OKAY
  input wire logic [1:0] SENSE_PIN, // sense_pin_1, sense_pin_0
  output logic STEP_OUT, // One-cycle step pulse
  output logic DIR_OUT, // 1 = counterclockwise
  output logic MOTOR_ON, // Motor sequence active
  output logic RAMPING // In a ramp phase
);
  // ==========================================================
  // Register file
  logic [7:0] ctrl_r;
  logic [1:0] pdir_r;
  logic [1:0] mask_r;
  logic [1:0] edge_r;
  logic [3:0] act_r;
  logic [15:0] rot_r;
  logic [7:0] xtra_r;
  logic [7:0] ramp_r;
  logic [7:0] addr_r;
  logic wr_ph_r;
  logic rd_ph_r;
  logic hready_r;
  logic [31:0] rdata_r;
  // Motor sequencing state
  srsp_pkg::srsp_state_t st_r;
  srsp_pkg::srsp_state_t st_nxt;
  logic [15:0] cnt_r;
  logic [15:0] cnt_nxt;
  logic [15:0] div_r;
  logic dir_r;
  logic dir_nxt;
  logic revp_r;
  logic revp_nxt;
  logic step_r;
  logic on_r;
  logic ramp_out_r;
  logic [1:0] s1_r;
  logic [1:0] s2_r;
  logic [1:0] s3_r;

  // ==========================================================
  // Bus decode; reads take one wait state so a write just before is seen
  wire acc_w = HSEL && HREADY && HTRANS[srsp_pkg::HTRANS_ACTIVE_BIT];
  wire wr_ctrl = wr_ph_r && (addr_r == srsp_pkg::A_CTRL);
  wire wr_pdir = wr_ph_r && (addr_r == srsp_pkg::A_PDIR);
  wire wr_mask = wr_ph_r && (addr_r == srsp_pkg::A_MASK);
  wire wr_edge = wr_ph_r && (addr_r == srsp_pkg::A_EDGE);
  wire wr_act = wr_ph_r && (addr_r == srsp_pkg::A_ACT);
  wire wr_rot = wr_ph_r && (addr_r == srsp_pkg::A_ROT);
  wire wr_xtra = wr_ph_r && (addr_r == srsp_pkg::A_XTRA);
  wire wr_ramp = wr_ph_r && (addr_r == srsp_pkg::A_RAMP);
  wire running = (st_r != srsp_pkg::ST_IDLE);
  wire [7:0] ctrl_rd = {running, ctrl_r[6:0]};
  wire [31:0] stat_rd = {8'h00, cnt_r, 3'h0, st_r};
  wire [31:0] rd_mux =
    (addr_r == srsp_pkg::A_CTRL) ? {24'h000000, ctrl_rd} :
    (addr_r == srsp_pkg::A_PDIR) ? {30'h00000000, pdir_r} :
    (addr_r == srsp_pkg::A_MASK) ? {30'h00000000, mask_r} :
    (addr_r == srsp_pkg::A_EDGE) ? {30'h00000000, edge_r} :
    (addr_r == srsp_pkg::A_ACT) ? {28'h0000000, act_r} :
    (addr_r == srsp_pkg::A_ROT) ? {16'h0000, rot_r} :
    (addr_r == srsp_pkg::A_XTRA) ? {24'h000000, xtra_r} :
    (addr_r == srsp_pkg::A_RAMP) ? {24'h000000, ramp_r} :
    (addr_r == srsp_pkg::A_STAT) ? stat_rd : 32'h00000000;

  // Bus phase tracking
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      addr_r <= 8'h00;
      wr_ph_r <= 1'b0;
      rd_ph_r <= 1'b0;
      hready_r <= 1'b1;
      rdata_r <= 32'h00000000;
    end else begin
      wr_ph_r <= acc_w && HWRITE;
      rd_ph_r <= acc_w && !HWRITE;
      hready_r <= !(acc_w && !HWRITE);
      if (acc_w) begin
        addr_r <= HADDR;
      end
      if (rd_ph_r) begin
        rdata_r <= rd_mux;
      end
    end
  end

  // Configuration registers; run bit is stored but unused, its read value reflects the state
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      ctrl_r <= srsp_pkg::CTRL_RST;
      pdir_r <= srsp_pkg::PIN_RST;
      mask_r <= srsp_pkg::PIN_RST;
      edge_r <= srsp_pkg::PIN_RST;
      act_r <= srsp_pkg::ACT_RST;
      rot_r <= srsp_pkg::ROT_RST;
      xtra_r <= srsp_pkg::XTRA_RST;
      ramp_r <= srsp_pkg::RAMP_RST;
    end else begin
      if (wr_ctrl) ctrl_r <= HWDATA[7:0];
      if (wr_pdir) pdir_r <= HWDATA[1:0];
      if (wr_mask) mask_r <= HWDATA[1:0];
      if (wr_edge) edge_r <= HWDATA[1:0];
      if (wr_act) act_r <= HWDATA[3:0];
      if (wr_rot) rot_r <= HWDATA[15:0];
      if (wr_xtra) xtra_r <= HWDATA[7:0];
      if (wr_ramp) ramp_r <= HWDATA[7:0];
    end
  end

  // ==========================================================
  // Sense pins: two-flop synchroniser plus one history flop, no filter
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      s1_r <= 2'h0;
      s2_r <= 2'h0;
      s3_r <= 2'h0;
    end else begin
      s1_r <= SENSE_PIN;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // Edge qualification; pin 0 wins when both pins fire together
  wire [1:0] rise_w = s2_r & ~s3_r;
  wire [1:0] fall_w = ~s2_r & s3_r;
  wire [1:0] evt_w = pdir_r & mask_r & ((rise_w & ~edge_r) | (fall_w & edge_r));
  wire rev_sel = evt_w[0] ? act_r[0] : act_r[1];
  wire xtra_sel = evt_w[0] ? act_r[srsp_pkg::ACT_XTRA_LSB] : act_r[srsp_pkg::ACT_XTRA_LSB + 1];

  // ==========================================================
  // Step timebase and host requests taken in the write data phase
  wire tick_w = (div_r == 16'(STEP_DIV - 1));
  wire done_w = tick_w && (cnt_r <= 16'h0001);
  wire start_req = wr_ctrl && HWDATA[srsp_pkg::C_RUN] && !running;
  wire stop_req = wr_ctrl && !HWDATA[srsp_pkg::C_RUN] && running;
  wire hard_w = HWDATA[srsp_pkg::C_HARD];
  wire rdn_w = HWDATA[srsp_pkg::C_RDN];
  wire can_rdn = rdn_w && (ramp_r != 8'h00);
  // Stop target by priority: hard stop, then ramp-down, then plain halt
  wire stop_to_rdn = !hard_w && can_rdn;
  // Pin action only at final speed; events in other states just drop
  wire irq_take = (st_r == srsp_pkg::ST_RUN) && (|evt_w) && (rev_sel || xtra_sel)
    && !stop_req;

  // Next state of the motor sequence
  always_comb begin
    st_nxt = st_r;
    cnt_nxt = (tick_w && (cnt_r != 16'h0000)) ? cnt_r - 16'h0001 : cnt_r;
    dir_nxt = dir_r;
    revp_nxt = revp_r;
    unique case (st_r)
      srsp_pkg::ST_IDLE: begin
        if (start_req) begin
          dir_nxt = HWDATA[srsp_pkg::C_DIR];
          if (HWDATA[srsp_pkg::C_RUP] && (ramp_r != 8'h00)) begin
            st_nxt = srsp_pkg::ST_RAMPUP;
            cnt_nxt = {8'h00, ramp_r};
          end else begin
            st_nxt = srsp_pkg::ST_RUN;
            cnt_nxt = rot_r;
          end
        end
      end
      srsp_pkg::ST_RAMPUP, srsp_pkg::ST_RUN, srsp_pkg::ST_EXTRA: begin
        if (stop_req) begin
          st_nxt = stop_to_rdn ? srsp_pkg::ST_RAMPDN : srsp_pkg::ST_IDLE;
          cnt_nxt = {8'h00, ramp_r};
        end else if (st_r == srsp_pkg::ST_RAMPUP) begin
          if (done_w) begin
            st_nxt = srsp_pkg::ST_RUN;
            cnt_nxt = rot_r;
          end
        end else if (irq_take) begin
          if (xtra_sel && (xtra_r != 8'h00)) begin
            st_nxt = srsp_pkg::ST_EXTRA;
            cnt_nxt = {8'h00, xtra_r};
            revp_nxt = rev_sel;
          end else begin
            dir_nxt = rev_sel ? !dir_r : dir_r;
            cnt_nxt = rot_r;
          end
        end else if (done_w && (st_r == srsp_pkg::ST_EXTRA)) begin
          dir_nxt = revp_r ? !dir_r : dir_r;
          st_nxt = srsp_pkg::ST_RUN;
          cnt_nxt = rot_r;
        end else if (done_w) begin
          // Ramp control still acts at final speed
          if (ctrl_r[srsp_pkg::C_RDN] && (ramp_r != 8'h00)) begin
            st_nxt = srsp_pkg::ST_RAMPDN;
            cnt_nxt = {8'h00, ramp_r};
          end else begin
            st_nxt = srsp_pkg::ST_IDLE;
          end
        end
      end
      srsp_pkg::ST_RAMPDN: begin
        // A soft stop here changes nothing; deceleration simply continues
        if ((stop_req && hard_w) || done_w) begin
          st_nxt = srsp_pkg::ST_IDLE;
        end
      end
      default: begin
        st_nxt = srsp_pkg::ST_IDLE;
      end
    endcase
  end

  // Sequence registers; divider restarts on start so the first step is whole
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      st_r <= srsp_pkg::ST_IDLE;
      cnt_r <= 16'h0000;
      div_r <= 16'h0000;
      dir_r <= 1'b0;
      revp_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      div_r <= (tick_w || start_req) ? 16'h0000 : div_r + 16'h0001;
      dir_r <= dir_nxt;
      revp_r <= revp_nxt;
    end
  end

  // Output flops
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      step_r <= 1'b0;
      on_r <= 1'b0;
      ramp_out_r <= 1'b0;
    end else begin
      step_r <= tick_w && running;
      on_r <= (st_nxt != srsp_pkg::ST_IDLE);
      ramp_out_r <= (st_nxt == srsp_pkg::ST_RAMPUP) || (st_nxt == srsp_pkg::ST_RAMPDN);
    end
  end

  assign HRDATA = rdata_r;
  assign HREADYOUT = hready_r;
  assign HRESP = 1'b0;
  assign STEP_OUT = step_r;
  assign DIR_OUT = dir_r;
  assign MOTOR_ON = on_r;
  assign RAMPING = ramp_out_r;

  // ==========================================================
  // Checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESETN);

  sequence s_extra_end;
    (st_r == srsp_pkg::ST_EXTRA) && done_w && revp_r && !stop_req;
  endsequence

  ramp_ignore_a: assert property (
    (st_r == srsp_pkg::ST_RAMPUP) && (|evt_w) && !stop_req |=> $stable(dir_r))
    else $error("pin event changed direction during ramp-up");
  ramp_hold_a: assert property (
    (st_r == srsp_pkg::ST_RAMPUP) && !stop_req && !tick_w |=> st_r == srsp_pkg::ST_RAMPUP)
    else $error("ramp-up left without stop or step");
  up_hard_a: assert property (
    (st_r == srsp_pkg::ST_RAMPUP) && stop_req && hard_w |=> st_r == srsp_pkg::ST_IDLE)
    else $error("hard stop in ramp-up did not halt");
  up_soft_a: assert property (
    (st_r == srsp_pkg::ST_RAMPUP) && stop_req && !hard_w && can_rdn
    |=> st_r == srsp_pkg::ST_RAMPDN && cnt_r == {8'h00, ramp_r})
    else $error("soft stop in ramp-up did not ramp down");
  up_plain_a: assert property (
    (st_r == srsp_pkg::ST_RAMPUP) && stop_req && !hard_w && !rdn_w |=> !MOTOR_ON)
    else $error("plain stop in ramp-up did not halt");
  dn_hard_a: assert property (
    (st_r == srsp_pkg::ST_RAMPDN) && stop_req && hard_w |=> st_r == srsp_pkg::ST_IDLE)
    else $error("hard stop in ramp-down did not halt");
  dn_keep_a: assert property (
    (st_r == srsp_pkg::ST_RAMPDN) && stop_req && !hard_w && !done_w
    |=> st_r == srsp_pkg::ST_RAMPDN)
    else $error("soft stop in ramp-down broke deceleration");
  run_reverse_a: assert property (
    irq_take && rev_sel && !(xtra_sel && xtra_r != 8'h00)
    |=> dir_r != $past(dir_r) && cnt_r == rot_r)
    else $error("reverse event did not flip and reload");
  run_end_a: assert property (
    (st_r == srsp_pkg::ST_RUN) && done_w && !irq_take && !stop_req
    && ctrl_r[srsp_pkg::C_RDN] && ramp_r != 8'h00 |=> st_r == srsp_pkg::ST_RAMPDN)
    else $error("rotation end did not enter ramp-down");
  extra_first_a: assert property (
    irq_take && xtra_sel && xtra_r != 8'h00 |=> st_r == srsp_pkg::ST_EXTRA && $stable(dir_r))
    else $error("extra steps not taken before reversal");
  extra_flip_a: assert property (
    s_extra_end |=> st_r == srsp_pkg::ST_RUN && dir_r != $past(dir_r))
    else $error("no reversal after extra steps");
  evt_gate_a: assert property (
    evt_w[0] |-> pdir_r[0] && mask_r[0] && $past(SENSE_PIN[0], 2) != $past(SENSE_PIN[0], 3))
    else $error("pin event without input, mask or edge");
endmodule // srsp_top

// [tb/srsp_sensor.sv]
// Behavioural sensor driving the two sense pins with clean levels
`timescale 1ns/1ns
module srsp_sensor (
  input wire logic clk, // Bench clock
  input wire logic [1:0] want, // Level asked for by the bench
  output logic [1:0] pin = 2'h0 // Sense pin levels
);
  // Registered so every change is one clean edge, never a glitch
  always @(posedge clk) begin
    pin <= want;
  end
endmodule // srsp_sensor

// [tb/tb.sv]
// Self-checking testbench of the stepper ramp and stop priority block
`timescale 1ns/1ns
module tb;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [7:0] haddr = 8'h00;
  logic [31:0] hwdata = 32'h0;
  logic [1:0] want = 2'h0;
  wire logic hready;
  wire logic [31:0] hrdata;
  wire logic [1:0] pin;
  wire logic dir_out;
  wire logic step_out;
  wire logic motor_on;
  wire logic ramping;
  wire logic hresp;
  int n_steps = 0;
  int errors = 0;
  int n_compared = 0;
  // ==========================================================
  // Clock, design and sensor
  initial begin
    forever #5 clk = ~clk;
  end
  srsp_top #(.STEP_DIV(4)) i_srsp_top (.CLK(clk), .RESETN(resetn), .HSEL(hsel),
    .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata),
    .HREADY(hready), .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(hresp), .SENSE_PIN(pin),
    .STEP_OUT(step_out), .DIR_OUT(dir_out), .MOTOR_ON(motor_on), .RAMPING(ramping));
  // Step pulses counted in the cycle they stand
  always @(posedge clk) begin
    if (step_out === 1'b1) n_steps <= n_steps + 1;
  end
  srsp_sensor i_srsp_sensor (.clk(clk), .want(want), .pin(pin));
  // ==========================================================
  // Checking and closing
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // ==========================================================
  // Bus and helper tasks
  // Address phase held until ready, then data phase held until ready
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rdv);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hready !== 1'b1);
    rdv = hrdata;
    chk("resp", {31'h0, hresp}, 32'h0);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] dummy;
    bus(1'b1, a, d, dummy);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    bus(1'b0, a, 32'h0, d);
  endtask
  task automatic chk_st(input logic [4:0] s);
    logic [31:0] v;
    rd(srsp_pkg::A_STAT, v);
    chk("state", {27'h0, v[4:0]}, {27'h0, s});
    chk("motor_on", {31'h0, motor_on}, {31'h0, (s != srsp_pkg::ST_IDLE)});
    chk("ramping", {31'h0, ramping},
      {31'h0, ((s == srsp_pkg::ST_RAMPUP) || (s == srsp_pkg::ST_RAMPDN))});
  endtask
  // Polls the state; the check after it judges whether it arrived
  task automatic wait_st(input logic [4:0] s);
    logic [31:0] v;
    v = 32'h0;
    for (int i = 0; i < 150 && v[4:0] !== s; i++) begin
      rd(srsp_pkg::A_STAT, v);
    end
  endtask
  // Short clean pulse; no debounce means three cycles are enough
  task automatic pulse(input int p);
    @(posedge clk);
    want[p] <= 1'b1;
    repeat (3) @(posedge clk);
    want[p] <= 1'b0;
    repeat (6) @(posedge clk);
  endtask
  // ==========================================================
  // Scenarios
  task automatic regs_reset();
    logic [31:0] v;
    rd(srsp_pkg::A_ROT, v);
    chk("rot", v, {16'h0, srsp_pkg::ROT_RST});
    rd(srsp_pkg::A_RAMP, v);
    chk("ramp", v, {24'h0, srsp_pkg::RAMP_RST});
    wr(8'h24, 32'hffffffff);
    rd(8'h24, v);
    chk("unmapped", v, 32'h0);
  endtask
  // Stop during ramp-up for each setting; stored ramp-down bit stays set
  task automatic ramp_up_stop();
    logic [7:0] stopv [3] = '{8'h06, 8'h04, 8'h00};
    logic [4:0] exp_s [3] = '{srsp_pkg::ST_IDLE, srsp_pkg::ST_RAMPDN, srsp_pkg::ST_IDLE};
    for (int i = 0; i < 3; i++) begin
      wr(srsp_pkg::A_CTRL, 32'h8c);
      chk_st(srsp_pkg::ST_RAMPUP);
      wr(srsp_pkg::A_CTRL, {24'h0, stopv[i]});
      chk_st(exp_s[i]);
      wait_st(srsp_pkg::ST_IDLE);
    end
  endtask
  // Hard stop cuts ramp-down; a soft stop lets every ramp step run out
  task automatic ramp_down_stop();
    int s0;
    s0 = 0;
    wr(srsp_pkg::A_ROT, 32'h1);
    for (int h = 1; h >= 0; h--) begin
      s0 = n_steps;
      wr(srsp_pkg::A_CTRL, 32'h84);
      wait_st(srsp_pkg::ST_RAMPDN);
      wr(srsp_pkg::A_CTRL, (h == 1) ? 32'h06 : 32'h04);
      chk_st((h == 1) ? srsp_pkg::ST_IDLE : srsp_pkg::ST_RAMPDN);
    end
    wait_st(srsp_pkg::ST_IDLE);
    chk_st(srsp_pkg::ST_IDLE);
    chk("steps", 32'(n_steps - s0), 32'(1 + srsp_pkg::RAMP_RST));
  endtask
  task automatic pin_reverse();
    wr(srsp_pkg::A_PDIR, 32'h3);
    wr(srsp_pkg::A_MASK, 32'h3);
    wr(srsp_pkg::A_EDGE, 32'h0);
    wr(srsp_pkg::A_ACT, 32'h3);
    wr(srsp_pkg::A_ROT, 32'd40);
    wr(srsp_pkg::A_CTRL, 32'h8c);
    pulse(0);
    chk("dir", {31'h0, dir_out}, 32'h0);
    chk_st(srsp_pkg::ST_RAMPUP);
    wait_st(srsp_pkg::ST_RUN);
    pulse(0);
    chk("dir", {31'h0, dir_out}, 32'h1);
    pulse(1);
    chk("dir", {31'h0, dir_out}, 32'h0);
    wr(srsp_pkg::A_MASK, 32'h2);
    pulse(0);
    chk("dir", {31'h0, dir_out}, 32'h0);
    wait_st(srsp_pkg::ST_RAMPDN);
    chk_st(srsp_pkg::ST_RAMPDN);
    pulse(1);
    chk("dir", {31'h0, dir_out}, 32'h0);
    wait_st(srsp_pkg::ST_IDLE);
  endtask
  // Stored control has ramp-down off; the stop write's own bit must rule
  task automatic extra_steps();
    wr(srsp_pkg::A_MASK, 32'h3);
    wr(srsp_pkg::A_ACT, 32'h5);
    wr(srsp_pkg::A_XTRA, 32'h6);
    wr(srsp_pkg::A_CTRL, 32'h80);
    pulse(0);
    chk("dir", {31'h0, dir_out}, 32'h0);
    chk_st(srsp_pkg::ST_EXTRA);
    wait_st(srsp_pkg::ST_RUN);
    chk("dir", {31'h0, dir_out}, 32'h1);
    wr(srsp_pkg::A_CTRL, 32'h04);
    chk_st(srsp_pkg::ST_RAMPDN);
    wait_st(srsp_pkg::ST_IDLE);
  endtask
  // ==========================================================
  // Main sequence and watchdog
  initial begin
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    regs_reset();
    ramp_up_stop();
    ramp_down_stop();
    pin_reverse();
    extra_steps();
    conclude();
  end
  // Whole run needs under a thousand cycles; this limit of 20000 cycles is far beyond it
  initial begin
    #200000;
    errors++;
    conclude();
  end
endmodule // tb
